// >>> bench/rioc_front_model.sv
// Front end model: the crystal oscillator that the bank switches on.
// Assumes osc_enable comes from rioc_top on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rioc_front_model
#(
	parameter int START = 5
)
(
	input wire logic hclk,
	input wire logic osc_enable,
	output logic xtal_running
);
	int cnt = 0;
	initial xtal_running = 1'b0;
	// Starts START cycles after enable, stops at once; START sets prompt or slow
	always @(posedge hclk)
	begin
		cnt <= osc_enable ? cnt + 1 : 0;
		xtal_running <= osc_enable && cnt >= START;
	end
endmodule
`default_nettype wire

// >>> bench/rioc_properties.sv
// Checker for the reader IO and operation control bank.
// Bound to rioc_top; sees only its ports.
`include "rioc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module rioc_check
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hrdata,
	input wire logic field_on_event,
	input wire logic peer_tx_done,
	input wire logic clock_out,
	input wire logic single_drive,
	input wire logic xtal_double,
	input wire logic [6:0] rx_water_level,
	input wire logic [6:0] tx_water_level,
	input wire logic [1:0] rx_channel_en,
	input wire logic rx_auto_select,
	input wire logic tx_enable
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic [3:0] wr_q;
	logic [9:0] hi_q;
	// Age of the last write, and how long the host clock has stood high
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_q <= 4'hF;
			hi_q <= 10'h000;
		end
		else
		begin
			wr_q <= (hsel && htrans[1] && hwrite) ? 4'h0 : wr_q + {3'h0, ~&wr_q};
			hi_q <= clock_out ? hi_q + 10'h001 : 10'h000;
		end
	end
	property p_rx_lvl; rx_water_level == 7'h40 || rx_water_level == 7'h50; endproperty
	a_rx_lvl: assert property (p_rx_lvl) else $error("receive level off");
	property p_tx_lvl; tx_water_level == 7'h20 || tx_water_level == 7'h10; endproperty
	a_tx_lvl: assert property (p_tx_lvl) else $error("transmit level off");
	// Drive, crystal and receive level settings only move after software writes them
	property p_quiet; $changed({single_drive, xtal_double, rx_water_level}) |-> wr_q < 4'h6; endproperty
	a_quiet: assert property (p_quiet) else $error("setting moved unasked");
	property p_auto; rx_auto_select |-> rx_channel_en == 2'b11; endproperty
	a_auto: assert property (p_auto) else $error("auto select with one channel");
	property p_chan; rx_channel_en != 2'b00; endproperty
	a_chan: assert property (p_chan) else $error("no receive channel");
	property p_tx_set; $rose(field_on_event) |-> ##[1:8] tx_enable; endproperty
	a_tx_set: assert property (p_tx_set) else $error("field on did not set tx");
	property p_tx_clr; $rose(peer_tx_done) && !field_on_event |-> ##[1:8] !tx_enable; endproperty
	a_tx_clr: assert property (p_tx_clr) else $error("tx not cleared");
	// The slowest legal high phase is the fallback clock half period
	property p_half; hi_q <= `RIOC_SLOW_HALF; endproperty
	a_half: assert property (p_half) else $error("host clock high too long");
	property p_upper; hrdata[31:8] == 24'h00_0000; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	c_tx: cover property ($rose(tx_enable));
	c_lvl: cover property (rx_water_level == 7'h50);
	c_slow: cover property (hi_q > 10'h100);
endmodule
bind rioc_top rioc_check u_check
(
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hrdata(hrdata), .field_on_event(field_on_event), .peer_tx_done(peer_tx_done),
	.clock_out(clock_out), .single_drive(single_drive), .xtal_double(xtal_double),
	.rx_water_level(rx_water_level), .tx_water_level(tx_water_level),
	.rx_channel_en(rx_channel_en), .rx_auto_select(rx_auto_select), .tx_enable(tx_enable)
);
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for rioc_top over AHB-Lite.
// Assumes rioc_front_model supplies the oscillator status.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'b00;
	logic [31:0] hwdata = 32'h0000_0000, rdata;
	logic cs_n = 1'b1, driving = 1'b0, pick = 1'b0, fon = 1'b0, done = 1'b0;
	wire hreadyout, hresp, clock_out, xtal_running, single_drive, use_driver_b, xtal_double;
	wire dataout_pulldown, osc_enable, rx_enable, rx_auto_select, tx_enable, wakeup_enable;
	wire [31:0] hrdata;
	wire [6:0] rx_water_level, tx_water_level;
	wire [1:0] rx_channel_en;
	int num_errors = 0, compares = 0;
	rioc_top u_dut
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .xtal_clk_pin(1'b0),
		.xtal_running(xtal_running), .chip_select_n(cs_n), .dataout_driving(driving),
		.channel_pick_bit(pick), .field_on_event(fon), .peer_tx_done(done),
		.clock_out(clock_out), .single_drive(single_drive), .use_driver_b(use_driver_b),
		.rx_water_level(rx_water_level), .tx_water_level(tx_water_level),
		.xtal_double(xtal_double), .dataout_pulldown(dataout_pulldown),
		.osc_enable(osc_enable), .rx_enable(rx_enable), .rx_channel_en(rx_channel_en),
		.rx_auto_select(rx_auto_select), .tx_enable(tx_enable), .wakeup_enable(wakeup_enable)
	);
	rioc_front_model u_front (.hclk(hclk), .osc_enable(osc_enable), .xtal_running(xtal_running));
	always #10 hclk = ~hclk;
	task automatic wrap_up();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// Bounded wait for hready; running out ends the run
	task automatic wait_ready();
		for (int n = 0; n < 20; n++)
		begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				return;
		end
		num_errors++;
		wrap_up();
	endtask
	// One single transfer, then an idle so a following read sees it
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		rdata = hrdata;
		@(posedge hclk);
	endtask
	task automatic settle();
		repeat (8) @(posedge hclk);
	endtask
	// Rising edges of the host clock seen in a window of w cycles
	task automatic rises(input int w, output int k);
		logic prev;
		settle();
		prev = clock_out;
		k = 0;
		repeat (w)
		begin
			@(posedge hclk);
			k += (clock_out === 1'b1 && prev === 1'b0);
			prev = clock_out;
		end
	endtask
	task automatic t_reset();
		xfer(8'h00, 1'b0, 0);
		chk("io one", 32'h0000_0008, rdata);
		xfer(8'h04, 1'b0, 0);
		chk("io two", 32'h0000_0000, rdata);
		xfer(8'h10, 1'b0, 0);
		chk("unmapped", 32'h0000_0000, rdata);
		xfer(8'h0C, 1'b0, 0);
		chk("status", 32'h0000_0001, rdata);
		chk("resp", 32'h0000_0000, {31'h0000_0000, hresp});
		chk("levels", 14'h2020, {rx_water_level, tx_water_level});
		$display("reset test done");
	endtask
	task automatic t_io();
		xfer(8'h00, 1'b1, 32'hFFFF_FFF3);
		xfer(8'h00, 1'b0, 0);
		chk("io one back", 32'h0000_00F3, rdata);
		settle();
		chk("drive", {single_drive, use_driver_b, xtal_double}, 3'b110);
		chk("levels", {rx_water_level, tx_water_level}, 14'h2810);
		xfer(8'h04, 1'b1, 32'hFFFF_FFFF);
		xfer(8'h04, 1'b0, 0);
		chk("io two back", 32'h0000_00DD, rdata);
		cs_n <= 1'b0;
		settle();
		chk("pd sel idle", dataout_pulldown, 1'b1);
		driving <= 1'b1;
		settle();
		chk("pd sel driving", dataout_pulldown, 1'b0);
		xfer(8'h04, 1'b1, 32'h0000_0008);
		settle();
		chk("pd idle sel", dataout_pulldown, 1'b0);
		cs_n <= 1'b1;
		settle();
		chk("pd idle", dataout_pulldown, 1'b1);
		$display("io test done");
	endtask
	task automatic t_op();
		xfer(8'h08, 1'b1, 32'h0000_00FF);
		xfer(8'h08, 1'b0, 0);
		chk("op back", 32'h0000_00FC, rdata);
		settle();
		chk("op out", {osc_enable, rx_enable, rx_auto_select, tx_enable, wakeup_enable}, 5'h1B);
		chk("one chan", rx_channel_en, 2'b01);
		pick <= 1'b1;
		settle();
		chk("one chan b", rx_channel_en, 2'b10);
		xfer(8'h08, 1'b1, 32'h0000_00D0);
		settle();
		chk("manual", {rx_channel_en, rx_auto_select}, 3'b110);
		xfer(8'h08, 1'b1, 32'h0000_00C0);
		settle();
		chk("auto", rx_auto_select, 1'b1);
		$display("operation test done");
	endtask
	task automatic t_clk();
		int k;
		int exp_k[4] = '{100, 200, 400, 0};
		for (int c = 0; c < 4; c++)
		begin
			xfer(8'h00, 1'b1, 32'h0000_0008 | (c << 1));
			rises(800, k);
			chk("clock edges", exp_k[c], k);
		end
		xfer(8'h08, 1'b1, 0);
		rises(800, k);
		chk("off stopped", 0, k);
		xfer(8'h00, 1'b1, 32'h0000_0008);
		rises(3124, k);
		chk("slow edges", 2, k);
		xfer(8'h00, 1'b1, 32'h0000_0009);
		rises(3124, k);
		chk("slow off", 0, k);
		$display("clock test done");
	endtask
	task automatic t_tx();
		fon <= 1'b1;
		settle();
		xfer(8'h08, 1'b0, 0);
		chk("tx set", {tx_enable, rdata}, 33'h1_0000_0008);
		fon <= 1'b0;
		done <= 1'b1;
		settle();
		chk("tx cleared", tx_enable, 1'b0);
		$display("transmit test done");
	endtask
	initial
	begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_io();
		t_op();
		t_clk();
		t_tx();
		wrap_up();
	end
endmodule
`default_nettype wire

// >>> rtl/rioc_map.svh
// Register offsets, field positions, reset values and timing counts for the
// reader IO and operation control bank. Included by rioc_top and rioc_check.
`ifndef RIOC_MAP_SVH
`define RIOC_MAP_SVH

// Register indices and byte addresses (index times four)
`define RIOC_IDX_IO_ONE 8'h00
`define RIOC_IDX_IO_TWO 8'h01
`define RIOC_IDX_OPCTL 8'h02
`define RIOC_ADDR_IO_ONE 8'h00
`define RIOC_ADDR_IO_TWO 8'h04
`define RIOC_ADDR_OPCTL 8'h08
`define RIOC_ADDR_EVENT 8'h0C

// First IO register fields
`define RIOC_B_SINGLE 7
`define RIOC_B_ALT_DRV 6
`define RIOC_B_RX_LVL 5
`define RIOC_B_TX_LVL 4
`define RIOC_B_XTAL 3
`define RIOC_B_CLK_HI 2
`define RIOC_B_CLK_LO 1
`define RIOC_B_SLOW_OFF 0
// Second IO register fields
`define RIOC_B_PD_SEL 4
`define RIOC_B_PD_IDLE 3
// Operation control fields
`define RIOC_B_EN 7
`define RIOC_B_RX_EN 6
`define RIOC_B_RX_ONE 5
`define RIOC_B_RX_MAN 4
`define RIOC_B_TX_EN 3
`define RIOC_B_WU 2

// Writable masks and power-up values
`define RIOC_MASK_IO_ONE 8'hFF
`define RIOC_MASK_IO_TWO 8'hDD
`define RIOC_MASK_OPCTL 8'hFC
`define RIOC_RST_IO_ONE 8'h08
`define RIOC_RST_IO_TWO 8'h00
`define RIOC_RST_OPCTL 8'h00

// Water levels in bytes
`define RIOC_RX_LVL_LO 7'h40
`define RIOC_RX_LVL_HI 7'h50
`define RIOC_TX_LVL_LO 7'h20
`define RIOC_TX_LVL_HI 7'h10

// Slow fallback clock: 32 kHz from 50 MHz, half period in cycles
`define RIOC_CLK_HZ 50000000
`define RIOC_SLOW_HZ 32000
`define RIOC_SLOW_HALF (`RIOC_CLK_HZ / (2 * `RIOC_SLOW_HZ))

`endif

// >>> rtl/rioc_pkg.sv
// Types for the reader IO and operation control bank.
// Assumes rioc_map.svh is on the include path.
package rioc_pkg;

	typedef enum logic [1:0]
	{
		RIOC_CLK_DIV4 = 2'b00,
		RIOC_CLK_DIV2 = 2'b01,
		RIOC_CLK_DIV1 = 2'b10,
		RIOC_CLK_OFF = 2'b11
	} rioc_clk_sel_e;

	typedef enum logic [1:0]
	{
		RIOC_BUS_IDLE = 2'b00,
		RIOC_BUS_WRITE = 2'b01,
		RIOC_BUS_READ = 2'b10
	} rioc_bus_e;

	typedef struct packed
	{
		logic [7:0] io_pin_setup_one;
		logic [7:0] io_pin_setup_two;
		logic [7:0] operation_control;
		rioc_bus_e phase;
		logic [7:0] addr;
		logic [31:0] rdata;
		logic [2:0] xtal_div;
		logic [10:0] slow_cnt;
		logic slow_clk;
		logic [1:0] xtal_sync;
		logic [1:0] cs_sync;
		logic [1:0] drv_sync;
		logic [2:0] tx_done_sync;
		logic [2:0] field_on_sync;
		logic clock_out;
		logic single_drive;
		logic use_driver_b;
		logic [6:0] rx_water_level;
		logic [6:0] tx_water_level;
		logic xtal_double;
		logic dataout_pulldown;
		logic osc_enable;
		logic rx_enable;
		logic [1:0] rx_channel_en;
		logic rx_auto_select;
		logic tx_enable;
		logic wakeup_enable;
	} rioc_state_s;

endpackage

// >>> rtl/rioc_top.sv
// Register bank for the reader IO and operation control of an HF reader
// front end, reached over AHB-Lite, with decoded control outputs.
// Assumes a single AHB-Lite master, one clock and asynchronous power-up reset.
//
// Behaviour
// - Bit 7 selects single driver antenna drive
// - Bit 6 picks driver pair A or B when bit 7 is set
// - Receive water level 64 or 80 bytes
// - Transmit water level 32 or 16 bytes
// - Bit 3 crystal select, powers up one
// - Clock field divides crystal clock for host
// - Clock field 11 holds output low
// - Slow 32 kHz clock when oscillator stopped
// - Defaults load only at power-up reset
// - Pull-down while selected and not driving
// - Pull-down whenever chip select is high
// - Bit 7 enables oscillator and regulator
// - Bit 6 enables receive operation
// - Bit 5 enables one or both channels
// - Bit 4 picks automatic or manual channel when bit 5 is clear
// - Bit 3 transmit, set and cleared automatically
// - Bit 2 enters wake-up mode
//
// Design decision made here: the AHB-Lite slave port.
`include "rioc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module rioc_top
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic xtal_clk_pin,
	input wire logic xtal_running,
	input wire logic chip_select_n,
	input wire logic dataout_driving,
	input wire logic channel_pick_bit,
	input wire logic field_on_event,
	input wire logic peer_tx_done,
	output logic clock_out,
	output logic single_drive,
	output logic use_driver_b,
	output logic [6:0] rx_water_level,
	output logic [6:0] tx_water_level,
	output logic xtal_double,
	output logic dataout_pulldown,
	output logic osc_enable,
	output logic rx_enable,
	output logic [1:0] rx_channel_en,
	output logic rx_auto_select,
	output logic tx_enable,
	output logic wakeup_enable
);

	localparam logic [10:0] SLOW_HALF = 11'(`RIOC_SLOW_HALF);

	rioc_pkg::rioc_state_s s_q;
	rioc_pkg::rioc_state_s s_d;
	logic [7:0] wbyte;
	logic tx_done_rise;
	logic field_on_rise;

	// Read mux shared by bus decode; unmapped offsets read zero
	function automatic logic [31:0] read_word(input logic [7:0] a,
		input rioc_pkg::rioc_state_s st);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			`RIOC_ADDR_IO_ONE: r = {24'h00_0000, st.io_pin_setup_one};
			`RIOC_ADDR_IO_TWO: r = {24'h00_0000, st.io_pin_setup_two};
			`RIOC_ADDR_OPCTL: r = {24'h00_0000, st.operation_control};
			`RIOC_ADDR_EVENT: r = {30'h0000_0000, st.xtal_sync[1], st.cs_sync[1]};
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	assign wbyte = hwdata[7:0];
	// Rise seen on the settled stage against its one-cycle-older copy
	assign tx_done_rise = s_q.tx_done_sync[1] & ~s_q.tx_done_sync[2];
	assign field_on_rise = s_q.field_on_sync[1] & ~s_q.field_on_sync[2];

	// Next-state logic for bus, registers, clocks and decoded outputs
	always_comb
	begin
		s_d = s_q;
		// Two-flop synchronisers; stage 1 feeds logic, stage 2 only the two rise detects
		s_d.xtal_sync = {s_q.xtal_sync[0], xtal_running};
		s_d.cs_sync = {s_q.cs_sync[0], chip_select_n};
		s_d.drv_sync = {s_q.drv_sync[0], dataout_driving};
		s_d.tx_done_sync = {s_q.tx_done_sync[1:0], peer_tx_done};
		s_d.field_on_sync = {s_q.field_on_sync[1:0], field_on_event};
		// Stage 2 is a history copy of stage 1; the first flop also feeds the status read, which samples stage 1 of s_d
		s_d.phase = rioc_pkg::RIOC_BUS_IDLE;

		// Data phase of the previous access
		if (s_q.phase == rioc_pkg::RIOC_BUS_WRITE)
		begin
			unique case (s_q.addr)
				`RIOC_ADDR_IO_ONE: s_d.io_pin_setup_one = wbyte & `RIOC_MASK_IO_ONE;
				`RIOC_ADDR_IO_TWO: s_d.io_pin_setup_two = wbyte & `RIOC_MASK_IO_TWO;
				`RIOC_ADDR_OPCTL: s_d.operation_control = wbyte & `RIOC_MASK_OPCTL;
				default: ;
			endcase
		end

		// Hardware events on the transmit bit; the set beats a software clear
		if (tx_done_rise)
			s_d.operation_control[`RIOC_B_TX_EN] = 1'b0;
		if (field_on_rise)
			s_d.operation_control[`RIOC_B_TX_EN] = 1'b1;

		// Address phase: zero-wait slave, register address for data phase
		if (hsel && hready && htrans[1])
		begin
			s_d.addr = haddr;
			s_d.phase = hwrite ? rioc_pkg::RIOC_BUS_WRITE : rioc_pkg::RIOC_BUS_READ;
			s_d.rdata = hwrite ? 32'h0000_0000 : read_word(haddr, s_d);
		end

		// Crystal-derived divider, reused for the host clock
		s_d.xtal_div = s_q.xtal_div + 3'h1;

		// Slow fallback clock from the system clock
		if (s_q.slow_cnt >= SLOW_HALF - 11'h001)
		begin
			s_d.slow_cnt = 11'h000;
			s_d.slow_clk = ~s_q.slow_clk;
		end
		else
			s_d.slow_cnt = s_q.slow_cnt + 11'h001;

		// Host clock output selection
		unique case (rioc_pkg::rioc_clk_sel_e'(s_q.io_pin_setup_one[`RIOC_B_CLK_HI:`RIOC_B_CLK_LO]))
			rioc_pkg::RIOC_CLK_OFF: s_d.clock_out = 1'b0;
			rioc_pkg::RIOC_CLK_DIV4:
				s_d.clock_out = s_q.xtal_sync[1] ? s_q.xtal_div[2]
					: (s_q.slow_clk & ~s_q.io_pin_setup_one[`RIOC_B_SLOW_OFF]);
			rioc_pkg::RIOC_CLK_DIV2:
				s_d.clock_out = s_q.xtal_sync[1] ? s_q.xtal_div[1]
					: (s_q.slow_clk & ~s_q.io_pin_setup_one[`RIOC_B_SLOW_OFF]);
			rioc_pkg::RIOC_CLK_DIV1:
				s_d.clock_out = s_q.xtal_sync[1] ? s_q.xtal_div[0]
					: (s_q.slow_clk & ~s_q.io_pin_setup_one[`RIOC_B_SLOW_OFF]);
		endcase

		// Antenna drive and water levels
		s_d.single_drive = s_q.io_pin_setup_one[`RIOC_B_SINGLE];
		s_d.use_driver_b = s_q.io_pin_setup_one[`RIOC_B_SINGLE]
			& s_q.io_pin_setup_one[`RIOC_B_ALT_DRV];
		s_d.rx_water_level = s_q.io_pin_setup_one[`RIOC_B_RX_LVL] ? `RIOC_RX_LVL_HI
			: `RIOC_RX_LVL_LO;
		s_d.tx_water_level = s_q.io_pin_setup_one[`RIOC_B_TX_LVL] ? `RIOC_TX_LVL_HI
			: `RIOC_TX_LVL_LO;
		s_d.xtal_double = s_q.io_pin_setup_one[`RIOC_B_XTAL];

		// Data-out pull-downs
		s_d.dataout_pulldown = (s_q.io_pin_setup_two[`RIOC_B_PD_SEL] & ~s_q.cs_sync[1]
			& ~s_q.drv_sync[1])
			| (s_q.io_pin_setup_two[`RIOC_B_PD_IDLE] & s_q.cs_sync[1]);

		// Operation control decode
		s_d.osc_enable = s_q.operation_control[`RIOC_B_EN];
		s_d.rx_enable = s_q.operation_control[`RIOC_B_RX_EN];
		if (s_q.operation_control[`RIOC_B_RX_ONE])
			s_d.rx_channel_en = channel_pick_bit ? 2'b10 : 2'b01;
		else
			s_d.rx_channel_en = 2'b11;
		s_d.rx_auto_select = ~s_q.operation_control[`RIOC_B_RX_ONE]
			& ~s_q.operation_control[`RIOC_B_RX_MAN];
		s_d.tx_enable = s_q.operation_control[`RIOC_B_TX_EN];
		s_d.wakeup_enable = s_q.operation_control[`RIOC_B_WU];
	end

	// Power-up reset is the only source of default values
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_q <= '0;
			s_q.io_pin_setup_one <= `RIOC_RST_IO_ONE;
			s_q.io_pin_setup_two <= `RIOC_RST_IO_TWO;
			s_q.operation_control <= `RIOC_RST_OPCTL;
			s_q.rx_water_level <= `RIOC_RX_LVL_LO;
			s_q.tx_water_level <= `RIOC_TX_LVL_LO;
			s_q.xtal_double <= 1'b1;
			s_q.rx_channel_en <= 2'b11;
			s_q.rx_auto_select <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// Zero-wait OKAY slave; outputs straight from state flops
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;
	assign clock_out = s_q.clock_out;
	assign single_drive = s_q.single_drive;
	assign use_driver_b = s_q.use_driver_b;
	assign rx_water_level = s_q.rx_water_level;
	assign tx_water_level = s_q.tx_water_level;
	assign xtal_double = s_q.xtal_double;
	assign dataout_pulldown = s_q.dataout_pulldown;
	assign osc_enable = s_q.osc_enable;
	assign rx_enable = s_q.rx_enable;
	assign rx_channel_en = s_q.rx_channel_en;
	assign rx_auto_select = s_q.rx_auto_select;
	assign tx_enable = s_q.tx_enable;
	assign wakeup_enable = s_q.wakeup_enable;

	// The crystal pin is represented by the divider on hclk; kept as a strap-free input
	logic unused_xtal_pin;
	assign unused_xtal_pin = xtal_clk_pin;

endmodule

`default_nettype wire
